// *** rtl/infrared_host_serial_bridge.sv ***
// Purpose: host serial and modem-line bridge to an infrared pulse link
// Assumes: pins synchronous to aclk; protocol stack runs in software on AXI4-Lite
// Notes: software reads host bytes and remote status, feeds the infrared
//        encoder and fills the packet buffer that drains to the host
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "irb_params.svh"
module infrared_host_serial_bridge #(
  parameter int unsigned POWERUP_CYCLES = `POWER_UP_CYCLES,
  parameter int unsigned LINK_TIMEOUT_CYCLES = `LINK_TIMEOUT_CYCLES,
  parameter int unsigned IDLE_CYCLES = `IDLE_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // host serial and modem lines
  input wire logic host_serial_in,
  output logic host_serial_out,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic cd_n,
  input wire logic ri_n,
  output logic cts_n,
  output logic dsr_n,
  // infrared transceiver
  input wire logic photodiode_in,
  output logic infrared_pulse_out,
  // open-collector activity pin
  output logic protocol_activity_out,
  output logic protocol_activity_oe
);
  // ---------------- bit clock and power-up
  logic [7:0] div_cnt;
  irb_pkg::power_seq_e pu_state;
  logic [31:0] pu_cnt;
  wire bit_tick = (div_cnt == 8'(`BITCLK_DIV - 1));
  wire ready = (pu_state == irb_pkg::PU_RUN);
  wire run_tick = bit_tick & ready;
  wire pu_last = (pu_cnt == ((pu_state == irb_pkg::PU_POWER) ?
                  POWERUP_CYCLES - 32'd1 : 32'(`OSC_STARTUP_CYCLES - 1)));

  always_ff @(posedge aclk) begin
    if (!aresetn || bit_tick) div_cnt <= 8'h00;
    else div_cnt <= div_cnt + 8'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pu_state <= irb_pkg::PU_POWER;
      pu_cnt <= 32'h0000_0000;
    end else begin
      case (pu_state)
        irb_pkg::PU_POWER, irb_pkg::PU_OSC: begin
          pu_cnt <= pu_last ? 32'h0000_0000 : pu_cnt + 32'h0000_0001;
          if (pu_last) begin
            pu_state <= (pu_state == irb_pkg::PU_POWER) ? irb_pkg::PU_OSC : irb_pkg::PU_RUN;
          end
        end
        irb_pkg::PU_RUN: pu_state <= irb_pkg::PU_RUN;
        default: pu_state <= irb_pkg::PU_POWER;
      endcase
    end
  end

  // ---------------- axi4-lite slave
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire do_write = aw_hold & w_hold & ~bvalid;
  wire wr_lane = do_write & w_strb[0];
  wire wr_ctrl = wr_lane & (aw_addr == `REG_CTRL);
  wire wr_status = wr_lane & (aw_addr == `REG_STATUS);
  wire wr_ir_tx = wr_lane & (aw_addr == `REG_IR_TX);
  wire wr_pkt = wr_lane & (aw_addr == `REG_PKT);
  wire wr_mapped = (aw_addr == `REG_CTRL) || (aw_addr == `REG_STATUS) ||
                   (aw_addr == `REG_HOST_IN) || (aw_addr == `REG_IR_TX) ||
                   (aw_addr == `REG_IR_RX) || (aw_addr == `REG_PKT) ||
                   (aw_addr == `REG_MODEM);
  wire rd_take = arvalid & ~rvalid;
  wire rd_mapped = (araddr == `REG_CTRL) || (araddr == `REG_STATUS) ||
                   (araddr == `REG_HOST_IN) || (araddr == `REG_IR_TX) ||
                   (araddr == `REG_IR_RX) || (araddr == `REG_PKT) ||
                   (araddr == `REG_MODEM);
  wire rd_host_in = rd_take & (araddr == `REG_HOST_IN);
  wire rd_ir_rx = rd_take & (araddr == `REG_IR_RX);

  assign awready = ~aw_hold;
  assign wready = ~w_hold;
  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && !w_hold) begin
        w_hold <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------- host receive path and 29-byte buffer
  logic [7:0] host_mem [0:`HOST_BUF_DEPTH-1];
  logic [4:0] host_wr;
  logic [4:0] host_rd;
  logic [4:0] host_count;
  logic [7:0] host_rx_data;
  logic host_rx_valid;
  wire host_push = host_rx_valid & ready & (host_count != 5'(`HOST_BUF_DEPTH));
  wire host_pop = rd_host_in & (host_count != 5'h00);
  wire host_ovf_set = host_rx_valid & ~host_push;

  serial_rx #(.IR(1'b0)) u_host_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(run_tick),
    .line(host_serial_in),
    .data(host_rx_data),
    .valid(host_rx_valid),
    .frame_err()
  );

  always_ff @(posedge aclk) begin
    if (host_push) host_mem[host_wr] <= host_rx_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_wr <= 5'h00;
      host_rd <= 5'h00;
      host_count <= 5'h00;
    end else begin
      if (host_push) host_wr <= (host_wr == 5'(`HOST_BUF_DEPTH - 1)) ? 5'h00 : host_wr + 5'h01;
      if (host_pop) host_rd <= (host_rd == 5'(`HOST_BUF_DEPTH - 1)) ? 5'h00 : host_rd + 5'h01;
      host_count <= host_count + {4'h0, host_push} - {4'h0, host_pop};
    end
  end

  // stop the host early so a slow sender still fits its trailing bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) cts_n <= 1'b1;
    else cts_n <= ~ready | (host_count >= 5'(`CTS_STOP_LEVEL));
  end

  // ---------------- infrared encoder and decoder
  logic ir_tx_busy;
  logic [7:0] ir_rx_data;
  logic ir_rx_valid;
  logic [7:0] ir_rx_hold;
  logic ir_rx_full;

  serial_tx #(.IR(1'b1)) u_ir_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(run_tick),
    .start(wr_ir_tx & ready),
    .data(w_data[7:0]),
    .line(infrared_pulse_out),
    .busy(ir_tx_busy)
  );

  serial_rx #(.IR(1'b1)) u_ir_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(run_tick),
    .line(photodiode_in & ready),
    .data(ir_rx_data),
    .valid(ir_rx_valid),
    .frame_err()
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_rx_hold <= 8'h00;
      ir_rx_full <= 1'b0;
    end else begin
      if (ir_rx_valid) ir_rx_hold <= ir_rx_data;
      ir_rx_full <= ir_rx_valid | (ir_rx_full & ~rd_ir_rx);
    end
  end

  // ---------------- 64-byte packet buffer draining to the host
  logic [7:0] pkt_mem [0:`PKT_MAX-1];
  logic [5:0] pkt_wr;
  logic [5:0] pkt_rd;
  logic [6:0] pkt_count;
  logic host_tx_busy;
  logic [31:0] to_cnt;
  wire pkt_waiting = (pkt_count != 7'h00);
  wire pkt_push = wr_pkt & (pkt_count != 7'(`PKT_MAX));
  wire pkt_ovf_set = wr_pkt & ~pkt_push;
  wire pkt_send = ready & pkt_waiting & ~rts_n & ~host_tx_busy;
  wire link_drop = pkt_waiting & rts_n & (to_cnt == LINK_TIMEOUT_CYCLES - 32'd1);

  serial_tx #(.IR(1'b0)) u_host_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(run_tick),
    .start(pkt_send),
    .data(pkt_mem[pkt_rd]),
    .line(host_serial_out),
    .busy(host_tx_busy)
  );

  always_ff @(posedge aclk) begin
    if (pkt_push) pkt_mem[pkt_wr] <= w_data[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || link_drop) begin
      pkt_wr <= 6'h00;
      pkt_rd <= 6'h00;
      pkt_count <= 7'h00;
    end else begin
      if (pkt_push) pkt_wr <= pkt_wr + 6'h01;
      if (pkt_send) pkt_rd <= pkt_rd + 6'h01;
      pkt_count <= pkt_count + {6'h00, pkt_push} - {6'h00, pkt_send};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !(pkt_waiting && rts_n) || link_drop) to_cnt <= 32'h0000_0000;
    else to_cnt <= to_cnt + 32'h0000_0001;
  end

  // ---------------- protocol state, link and power
  irb_pkg::proto_state_e pstate;
  logic low_power;
  logic [31:0] idle_cnt;
  // the three legal state codes are exactly the one-hot patterns
  wire ctrl_ok = $onehot(w_data[2:0]);
  wire ir_activity = photodiode_in | ir_tx_busy | wr_ir_tx;
  wire link_up = ready & (pstate == irb_pkg::PS_RESPONSE);
  wire proto_active = ready & ~low_power &
                      (pstate != irb_pkg::PS_DISCONNECT);

  // only one primary is ever served, so a timeout simply returns to disconnect
  always_ff @(posedge aclk) begin
    if (!aresetn || link_drop) pstate <= irb_pkg::PS_DISCONNECT;
    else if (wr_ctrl && ctrl_ok) pstate <= irb_pkg::proto_state_e'(w_data[2:0]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ready || ir_activity) begin
      idle_cnt <= 32'h0000_0000;
      low_power <= 1'b0;
    end else if (idle_cnt == IDLE_CYCLES - 32'd1) begin
      low_power <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsr_n <= 1'b1;
      protocol_activity_out <= 1'b0;
      protocol_activity_oe <= 1'b1;
    end else begin
      dsr_n <= ~link_up;
      protocol_activity_out <= 1'b0;
      protocol_activity_oe <= ~proto_active;
    end
  end

  // ---------------- modem status to the primary and sticky flags
  logic remote_dsr;
  logic remote_cd;
  logic remote_ri;
  logic host_ovf;
  logic pkt_ovf;
  logic ir_overrun;
  logic link_to;
  wire [3:0] clr = wr_status ? w_data[7:4] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_dsr <= 1'b0;
      remote_cd <= 1'b0;
      remote_ri <= 1'b0;
      host_ovf <= 1'b0;
      ir_overrun <= 1'b0;
      pkt_ovf <= 1'b0;
      link_to <= 1'b0;
    end else begin
      remote_dsr <= ~dtr_n;
      remote_cd <= ~cd_n;
      remote_ri <= ~ri_n;
      host_ovf <= host_ovf_set | (host_ovf & ~clr[0]);
      ir_overrun <= (ir_rx_valid & ir_rx_full & ~rd_ir_rx) | (ir_overrun & ~clr[1]);
      pkt_ovf <= pkt_ovf_set | (pkt_ovf & ~clr[2]);
      link_to <= link_drop | (link_to & ~clr[3]);
    end
  end

  // ---------------- read data
  wire [31:0] status_word = {9'h000, pkt_count, 3'h0, host_count, link_to, pkt_ovf,
                             ir_overrun, host_ovf, ir_rx_full, ir_tx_busy, low_power, ready};
  wire [31:0] modem_word = {8'h00, `SERVICE_CLASS_CODE, `ADVERT_BAUD_CODE,
                            4'h0, ~rts_n, remote_ri, remote_cd, remote_dsr};
  wire [31:0] rd_mux =
    (araddr == `REG_CTRL) ? {29'h0000_0000, pstate} :
    (araddr == `REG_STATUS) ? status_word :
    (araddr == `REG_HOST_IN) ? {23'h00_0000, host_count != 5'h00, host_mem[host_rd]} :
    (araddr == `REG_IR_TX) ? {31'h0000_0000, ir_tx_busy} :
    (araddr == `REG_IR_RX) ? {23'h00_0000, ir_rx_full, ir_rx_hold} :
    (araddr == `REG_PKT) ? {25'h000_0000, pkt_count} :
    (araddr == `REG_MODEM) ? modem_word : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// *** rtl/irb_params.svh ***
// Purpose: constants of the infrared host serial bridge
// Assumes: 25 MHz aclk
// Notes: register offsets are byte addresses on the AXI4-Lite slave
`ifndef IRB_PARAMS_SVH
`define IRB_PARAMS_SVH

`define CLK_HZ 25000000
`define BAUD_RATE 9600
`define TICKS_PER_BIT 16
// nearest integer divide of the clock down to 16 ticks per bit
`define BITCLK_DIV ((`CLK_HZ + (`BAUD_RATE * `TICKS_PER_BIT) / 2) / (`BAUD_RATE * `TICKS_PER_BIT))
`define ZERO_LOW_LEAD 7
`define ZERO_PULSE_LEN 3
`define HALF_BIT 8
`define FRAME_BITS 10

`define HOST_BUF_DEPTH 29
`define CTS_SLACK 6
`define CTS_STOP_LEVEL (`HOST_BUF_DEPTH - `CTS_SLACK)
`define PKT_MAX 64

`define CYC_PER_US (`CLK_HZ / 1000000)
`define POWER_UP_DELAY_US 1000
`define POWER_UP_CYCLES (`POWER_UP_DELAY_US * `CYC_PER_US)
`define OSC_STARTUP_CYCLES 1024
`define LINK_TIMEOUT_MS 3000
`define LINK_TIMEOUT_CYCLES (`LINK_TIMEOUT_MS * 1000 * `CYC_PER_US)
`define IDLE_TIMEOUT_MS 100
`define IDLE_CYCLES (`IDLE_TIMEOUT_MS * 1000 * `CYC_PER_US)

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_HOST_IN 8'h08
`define REG_IR_TX 8'h0C
`define REG_IR_RX 8'h10
`define REG_PKT 8'h14
`define REG_MODEM 8'h18

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// advertised rate and service class codes carried in the modem register
`define ADVERT_BAUD_CODE 8'h02
`define SERVICE_CLASS_CODE 8'h04

`endif

// *** rtl/irb_pkg.sv ***
// Purpose: types of the infrared host serial bridge
// Assumes: nothing
// Notes: one-hot state codes
package irb_pkg;
  typedef enum logic [2:0] {
    PS_DISCONNECT = 3'b001,
    PS_DISCOVERY = 3'b010,
    PS_RESPONSE = 3'b100
  } proto_state_e;

  typedef enum logic [2:0] {
    PU_POWER = 3'b001,
    PU_OSC = 3'b010,
    PU_RUN = 3'b100
  } power_seq_e;
endpackage

// *** rtl/serial_tx.sv ***
// Purpose: 8N1 frame transmitter, plain level or infrared pulse form
// Assumes: tick is a one-cycle pulse at 16 per bit
// Notes: line is registered, so it trails the internal bit by one clock
`timescale 1ns/1ns
`include "irb_params.svh"
module serial_tx #(
  parameter bit IR = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic [7:0] data,
  // line
  output logic line,
  output logic busy
);
  logic [9:0] shreg;
  logic [3:0] cnt;
  logic [3:0] idx;
  wire bit_end = tick & (cnt == 4'hF);
  wire in_pulse = (cnt >= 4'(`ZERO_LOW_LEAD)) &&
                  (cnt < 4'(`ZERO_LOW_LEAD + `ZERO_PULSE_LEN));
  // a zero becomes a short high pulse mid-bit, a one stays low
  wire next_line = IR ? (busy & ~shreg[0] & in_pulse) : (~busy | shreg[0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      shreg <= 10'h3FF;
      cnt <= 4'h0;
      idx <= 4'h0;
    end else if (start && !busy) begin
      busy <= 1'b1;
      shreg <= {1'b1, data, 1'b0};
      cnt <= 4'h0;
      idx <= 4'h0;
    end else if (busy && tick) begin
      cnt <= cnt + 4'h1;
      if (bit_end) begin
        shreg <= {1'b1, shreg[9:1]};
        idx <= idx + 4'h1;
        busy <= (idx != 4'(`FRAME_BITS - 1));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) line <= ~IR;
    else line <= next_line;
  end
endmodule

// *** rtl/serial_rx.sv ***
// Purpose: 8N1 frame receiver, plain level or infrared pulse form
// Assumes: tick is a one-cycle pulse at 16 per bit
// Notes: infrared data-bit pulses are caught on every clock, the start pulse only on a tick
`timescale 1ns/1ns
`include "irb_params.svh"
module serial_rx #(
  parameter bit IR = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // line
  input wire logic tick,
  input wire logic line,
  // received byte
  output logic [7:0] data,
  output logic valid,
  output logic frame_err
);
  logic active;
  logic pulse_seen;
  logic [3:0] cnt;
  logic [3:0] idx;
  logic [7:0] shreg;
  wire start_mark = IR ? line : ~line;
  // the start window is half a bit, so later windows centre on the bits
  wire win_end = tick & (cnt == ((idx == 4'h0) ? 4'(`HALF_BIT - 1) : 4'hF));
  wire bit_val = IR ? ~(pulse_seen | line) : line;
  wire false_start = ~IR & line & (idx == 4'h0);
  wire last = (idx == 4'(`FRAME_BITS - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= 1'b0;
      pulse_seen <= 1'b0;
      cnt <= 4'h0;
      idx <= 4'h0;
      shreg <= 8'h00;
      data <= 8'h00;
      valid <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      valid <= 1'b0;
      frame_err <= 1'b0;
      if (!active) begin
        if (tick && start_mark) begin
          active <= 1'b1;
          cnt <= 4'h0;
          idx <= 4'h0;
          pulse_seen <= 1'b0;
        end
      end else if (win_end) begin
        cnt <= 4'h0;
        idx <= idx + 4'h1;
        pulse_seen <= 1'b0;
        if (idx != 4'h0 && !last) shreg <= {bit_val, shreg[7:1]};
        if (false_start || last) active <= 1'b0;
        if (last) begin
          data <= shreg;
          valid <= bit_val;
          frame_err <= ~bit_val;
        end
      end else begin
        pulse_seen <= pulse_seen | (IR & line);
        if (tick) cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// *** bench/bridge_assertions.sv ***
// Purpose: port-level checks of the infrared host serial bridge
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound into every instance of the bridge
`timescale 1ns/1ns
`include "irb_params.svh"
module bridge_checker #(
  parameter int unsigned POWERUP_CYCLES = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // pins
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic host_serial_out,
  input wire logic infrared_pulse_out,
  input wire logic protocol_activity_out,
  input wire logic protocol_activity_oe
);
  localparam int unsigned PULSE = `BITCLK_DIV * `ZERO_PULSE_LEN;
  localparam int unsigned GAP = `BITCLK_DIV * (`TICKS_PER_BIT - `ZERO_PULSE_LEN);
  logic [15:0] high_cnt;
  logic [15:0] low_cnt;
  logic [31:0] up_cnt;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // low count saturates so the first pulse after reset is never judged too close
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_cnt <= 16'h0000;
      low_cnt <= 16'hFFFF;
      up_cnt <= 32'h0000_0000;
    end else begin
      high_cnt <= infrared_pulse_out ? high_cnt + 16'h0001 : 16'h0000;
      low_cnt <= infrared_pulse_out ? 16'h0000 : low_cnt + {15'h0000, low_cnt != 16'hFFFF};
      up_cnt <= up_cnt + {31'h0000_0000, up_cnt != 32'hFFFF_FFFF};
    end
  end

  sequence aw_w_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence resp_soon;
    ##[1:2] bvalid;
  endsequence
  sequence ar_taken;
    arvalid && arready;
  endsequence

  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    cts_n && dsr_n && host_serial_out && !infrared_pulse_out && protocol_activity_oe)
    else $error("outputs not idle after reset");
  a_startup_quiet: assert property (up_cnt < POWERUP_CYCLES + 1024 |->
    cts_n && !infrared_pulse_out)
    else $error("traffic before start-up delays ended");
  a_activity_drive: assert property (protocol_activity_oe |-> !protocol_activity_out)
    else $error("activity pin driven high");
  a_pulse_width: assert property ($fell(infrared_pulse_out) |-> high_cnt == PULSE)
    else $error("infrared pulse width wrong");
  a_pulse_gap: assert property ($rose(infrared_pulse_out) |-> low_cnt >= GAP)
    else $error("infrared pulses too close");
  a_write_answer: assert property (aw_w_taken |-> resp_soon)
    else $error("write response late");
  a_write_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  a_read_answer: assert property (ar_taken |=> rvalid)
    else $error("read data late");
  a_read_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read data not released");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
endmodule

bind infrared_host_serial_bridge bridge_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) bridge_checker_i (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
  .rvalid, .rready, .cts_n, .dsr_n, .host_serial_out, .infrared_pulse_out,
  .protocol_activity_out, .protocol_activity_oe);

// *** bench/host_ir_partner.sv ***
// Purpose: host UART and remote infrared primary facing the bridge
// Assumes: tasks are entered just after a rising clock edge
// Notes: idle host line is high, idle photodiode is dark (low)
`timescale 1ns/1ns
module host_ir_partner #(
  parameter int TICK = 163,
  parameter int BIT = 16 * TICK
) (
  // clock
  input wire logic aclk,
  // host serial
  output logic host_serial_in,
  input wire logic host_serial_out,
  // infrared
  output logic photodiode_in,
  input wire logic infrared_pulse_out
);
  initial begin
    host_serial_in = 1'b1;
    photodiode_in = 1'b0;
  end

  task automatic host_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_serial_in <= f[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask

  task automatic host_get(output logic [7:0] b);
    do @(posedge aclk); while (host_serial_out);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge aclk);
      b[i] = host_serial_out;
    end
  endtask

  // a zero bit is a light pulse in ticks 7 to 9 of its bit time
  task automatic ir_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      repeat (7 * TICK) @(posedge aclk);
      photodiode_in <= !f[i];
      repeat (3 * TICK) @(posedge aclk);
      photodiode_in <= 1'b0;
      repeat (6 * TICK) @(posedge aclk);
    end
  endtask

  task automatic ir_get(output logic [7:0] b, output int w);
    w = 0;
    do @(posedge aclk); while (!infrared_pulse_out);
    while (infrared_pulse_out) begin
      w++;
      @(posedge aclk);
    end
    repeat (BIT + TICK - w) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      b[i] = !infrared_pulse_out;
      repeat (BIT) @(posedge aclk);
    end
  endtask
endmodule

// *** bench/testbench.sv ***
// Purpose: self-checking bench of the infrared host serial bridge
// Assumes: short power-up, idle and link timeout parameters
// Notes: bus tasks keep one AXI4-Lite transfer in flight at a time
`timescale 1ns/1ns
`include "irb_params.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic rts_n = 1'b1, dtr_n = 1'b1, cd_n = 1'b1, ri_n = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, host_serial_out, host_serial_in;
  logic cts_n, dsr_n, infrared_pulse_out, photodiode_in;
  logic protocol_activity_out, protocol_activity_oe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] ir_byte, host_byte;
  int pulse_w, failures = 0, tests_run = 0;
  irb_pkg::proto_state_e st [3] = '{irb_pkg::PS_DISCONNECT, irb_pkg::PS_DISCOVERY,
    irb_pkg::PS_RESPONSE};
  wire [4:0] idle_lines = {cts_n, dsr_n, host_serial_out, infrared_pulse_out,
    protocol_activity_oe};

  // idle span short enough to reach low power during the timeout wait
  infrared_host_serial_bridge #(.POWERUP_CYCLES(20), .LINK_TIMEOUT_CYCLES(5000),
    .IDLE_CYCLES(3000))
    infrared_host_serial_bridge_i (.*);
  host_ir_partner #(.TICK(`BITCLK_DIV)) host_ir_partner_i (.*);

  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    `CHK("write resp", r, bresp)
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    `CHK("read data", e, rdata & m)
    `CHK("read resp", r, rresp)
    @(posedge aclk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("reset lines", 5'b11101, idle_lines)
    rchk(`REG_STATUS, 32'h1, 32'h0, `RESP_OKAY);
    repeat (1100) @(posedge aclk);
    rchk(`REG_STATUS, 32'h1, 32'h1, `RESP_OKAY);
    `CHK("send pin", 1'b0, cts_n)
    for (int i = 0; i < 16; i++) begin
      {ri_n, cd_n, dtr_n, rts_n} <= i[3:0];
      repeat (4) @(posedge aclk);
      rchk(`REG_MODEM, 32'h00FFFF0F, {8'h00, `SERVICE_CLASS_CODE, `ADVERT_BAUD_CODE, 4'h0,
        ~i[0], ~i[3], ~i[2], ~i[1]}, `RESP_OKAY);
    end
    wr(8'h1C, 32'h0, `RESP_SLVERR);
    rchk(8'h1C, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
    foreach (st[k]) begin
      wr(`REG_CTRL, {29'h0, st[k]}, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("link pin", st[k] != irb_pkg::PS_RESPONSE, dsr_n)
      `CHK("activity pin", st[k] == irb_pkg::PS_DISCONNECT, protocol_activity_oe)
    end
    fork
      host_ir_partner_i.host_send(8'h3C);
      begin
        wr(`REG_IR_TX, 32'hA5, `RESP_OKAY);
        rchk(`REG_STATUS, 32'h4, 32'h4, `RESP_OKAY);
      end
      host_ir_partner_i.ir_get(ir_byte, pulse_w);
    join
    `CHK("infrared byte", 8'hA5, ir_byte)
    `CHK("pulse width", `BITCLK_DIV * `ZERO_PULSE_LEN, pulse_w)
    rchk(`REG_HOST_IN, 32'h1FF, 32'h13C, `RESP_OKAY);
    rchk(`REG_HOST_IN, 32'h100, 32'h0, `RESP_OKAY);
    wr(`REG_PKT, 32'h5A, `RESP_OKAY);
    repeat (4900) @(posedge aclk);
    `CHK("link before timeout", 1'b0, dsr_n)
    repeat (120) @(posedge aclk);
    `CHK("link after timeout", 1'b1, dsr_n)
    rchk(`REG_STATUS, 32'h007F0082, 32'h82, `RESP_OKAY);
    wr(`REG_STATUS, 32'hF0, `RESP_OKAY);
    rchk(`REG_STATUS, 32'hF0, 32'h0, `RESP_OKAY);
    wr(`REG_CTRL, {29'h0, irb_pkg::PS_RESPONSE}, `RESP_OKAY);
    `CHK("link up", 1'b0, dsr_n)
    `CHK("asleep pin", 1'b1, protocol_activity_oe)
    rts_n <= 1'b0;
    fork
      wr(`REG_PKT, 32'hC3, `RESP_OKAY);
      host_ir_partner_i.host_get(host_byte);
      host_ir_partner_i.ir_send(8'h96);
    join
    `CHK("host byte", 8'hC3, host_byte)
    // the decoder closes its stop window up to a bit after the sender is done
    repeat (`TICKS_PER_BIT * `BITCLK_DIV) @(posedge aclk);
    rchk(`REG_IR_RX, 32'h1FF, 32'h196, `RESP_OKAY);
    wr(`REG_IR_TX, 32'h0F, `RESP_OKAY);
    `CHK("awake pin", 1'b0, protocol_activity_oe)
    final_report();
  end

  initial begin
    #(90000 * 40);
    failures++;
    final_report();
  end
endmodule
